// file: seae_exc.sv
// What this block does
// - data storage fault vectors 300, syndrome reports
// - syndrome bit for direct-store program exception
// - syndrome bit when all translations miss
// - syndrome bit when protection forbids access
// - flag set: external control/reserved ops flagged
// - flag set: external control to write-through
// - syndrome direction bit: store set, load clear
// - syndrome bit on breakpoint address match
// - syndrome bit on segment table miss
// - untranslatable fetch raises fetch fault, 400
// - fetch from direct-store segment faults
// - key and protection deny read: fault
// - interrupt pin raises external interrupt, 500
// - on interrupt stop dispatch, drain
// - dispatched instruction faults go first
// - unaligned word-class access raises alignment, 600
// - cache-zero to inhibited/write-through page faults
// - cache-zero with cache locked/disabled faults
// - little-endian unnatural alignment faults
// - multiple/string in little-endian faults
// - interrupt taken only while enable set
//
// The Wishbone register port and the register offsets are this design's own decisions.
`timescale 1ns/1ps

module seae_exc
	import seae_pkg::*;
(
	input  wire logic                   core_clk,
	input  wire logic                   reset,
	input  wire logic                   wb_cyc_i,
	input  wire logic                   wb_stb_i,
	input  wire logic                   wb_we_i,
	input  wire logic [7:0]             wb_adr_i,
	input  wire logic [3:0]             wb_sel_i,
	input  wire logic [31:0]            wb_dat_i,
	output logic      [31:0]            wb_dat_o,
	output logic                        wb_ack_o,
	input  wire seae_dacc_t             dacc,
	input  wire seae_fetch_t            fetch,
	input  wire seae_core_t             core,
	input  wire logic                   ext_irq,
	output logic                        stop_dispatch,
	output logic                        redirect_valid,
	output logic      [SEAE_VEC_W-1:0]  redirect_offset
);

	logic [SEAE_SYN_W-1:0]  syndrome;
	logic [1:0]             dbp_mode;
	logic [31:0]            dbp_addr;
	seae_state_t            state;
	logic                   pend_valid;
	logic [SEAE_VEC_W-1:0]  pend_vec;
	logic [SEAE_VEC_W-1:0]  last_vec;

	logic [SEAE_SYN_W-1:0]  next_syndrome;
	logic                   dfault;
	logic                   afault;
	logic                   ifault;
	logic                   irq_take;
	logic                   any_fault;
	logic                   word_class;
	logic                   ext_or_resv;
	logic                   key;
	logic [3:0]             nat_mask;
	logic                   dbp_hit;
	seae_state_t            next_state;
	logic                   wb_req;

	// data fault syndrome bits
	always_comb begin
		next_syndrome = '0;
		ext_or_resv = (dacc.op == seae_op_ext_ctl) || (dacc.op == seae_op_load_reserved) ||
			(dacc.op == seae_op_store_cond);
		dbp_hit = (dacc.addr[31:2] == dbp_addr[31:2]) && (dbp_mode != SEAE_MODE_OFF) &&
			((dbp_mode == SEAE_MODE_BOTH) || (dbp_mode == SEAE_MODE_WRITE && dacc.is_store) ||
			(dbp_mode == SEAE_MODE_READ && !dacc.is_store));
		next_syndrome[SEAE_SYN_DS_PROG] = dacc.ds_prog_exc;
		next_syndrome[SEAE_SYN_NO_XLAT] = dacc.miss_primary && dacc.miss_secondary && dacc.miss_block;
		next_syndrome[SEAE_SYN_PROT] = dacc.prot_denied;
		next_syndrome[SEAE_SYN_DS_ATOMIC] = dacc.segment_direct_store_flag && ext_or_resv;
		next_syndrome[SEAE_SYN_DS_WT] = dacc.segment_direct_store_flag && (dacc.op == seae_op_ext_ctl) &&
			dacc.write_through;
		next_syndrome[SEAE_SYN_DBP] = dbp_hit;
		next_syndrome[SEAE_SYN_SEG_MISS] = dacc.seg_table_miss;
		dfault = dacc.valid && (next_syndrome != '0);
		next_syndrome[SEAE_SYN_STORE] = dacc.is_store;
	end

	// alignment causes
	always_comb begin
		word_class = (dacc.op == seae_op_fp_ls) || (dacc.op == seae_op_multiple) ||
			(dacc.op == seae_op_load_reserved) || (dacc.op == seae_op_store_cond) ||
			(dacc.op == seae_op_ext_ctl);
		nat_mask = 4'((4'h1 << dacc.size_log2) - 4'h1);
		afault = 1'b0;
		if (word_class && (dacc.addr[1:0] != 2'h0)) begin
			afault = 1'b1;
		end
		if ((dacc.op == seae_op_dcbz) && (dacc.cache_inhibited || dacc.write_through)) begin
			afault = 1'b1;
		end
		if ((dacc.op == seae_op_dcbz) && (core.dcache_locked || core.dcache_disabled)) begin
			afault = 1'b1;
		end
		if (core.little_endian && ((dacc.addr[3:0] & nat_mask) != 4'h0)) begin
			afault = 1'b1;
		end
		if (core.little_endian && ((dacc.op == seae_op_multiple) || (dacc.op == seae_op_string))) begin
			afault = 1'b1;
		end
		afault = afault && dacc.valid;
	end

	// instruction fetch faults
	always_comb begin
		key = fetch.problem_state ? fetch.user_key_bit : fetch.supervisor_key_bit;
		ifault = fetch.valid && (fetch.xlat_fail || fetch.direct_store_seg ||
			(key && (fetch.page_protection_bits == 2'h0)));
	end

	assign any_fault = dfault || afault || ifault;

	assign irq_take = (state == seae_st_drain) && core.external_irq_enable_bit && ext_irq &&
		core.dispatched_empty && !any_fault && !pend_valid;

	always_comb begin
		next_state = state;
		case (state)
			seae_st_run: begin
				if (ext_irq && core.external_irq_enable_bit) begin
					next_state = seae_st_drain;
				end
			end
			seae_st_drain: begin
				if (irq_take) begin
					next_state = seae_st_release;
				end else if (!ext_irq || !core.external_irq_enable_bit) begin
					next_state = seae_st_run;
				end
			end
			seae_st_release: begin
				if (!ext_irq) begin
					next_state = seae_st_run;
				end
			end
			default: begin
				next_state = seae_st_run;
			end
		endcase
	end

	always_ff @(posedge core_clk or posedge reset) begin
		if (reset) begin
			state <= seae_st_run;
			stop_dispatch <= 1'b0;
		end else begin
			state <= next_state;
			stop_dispatch <= (next_state == seae_st_drain);
		end
	end

	always_ff @(posedge core_clk or posedge reset) begin
		if (reset) begin
			syndrome <= '0;
		end else if (dfault) begin
			syndrome <= next_syndrome;
		end
	end

	// fault selection, data first
	always_ff @(posedge core_clk or posedge reset) begin
		if (reset) begin
			pend_valid <= 1'b0;
			pend_vec <= '0;
		end else begin
			pend_valid <= any_fault || irq_take;
			if (dfault) begin
				pend_vec <= SEAE_VEC_DSI;
			end else if (afault) begin
				pend_vec <= SEAE_VEC_ALIGN;
			end else if (ifault) begin
				pend_vec <= SEAE_VEC_ISI;
			end else if (irq_take) begin
				pend_vec <= SEAE_VEC_EXT;
			end
		end
	end

	always_ff @(posedge core_clk or posedge reset) begin
		if (reset) begin
			redirect_valid <= 1'b0;
			redirect_offset <= '0;
			last_vec <= '0;
		end else begin
			redirect_valid <= pend_valid;
			if (pend_valid) begin
				redirect_offset <= pend_vec;
				last_vec <= pend_vec;
			end
		end
	end

	// wishbone slave, one wait state
	assign wb_req = wb_cyc_i && wb_stb_i && !wb_ack_o;

	always_ff @(posedge core_clk or posedge reset) begin
		if (reset) begin
			wb_ack_o <= 1'b0;
			wb_dat_o <= SEAE_RST_WORD;
		end else begin
			wb_ack_o <= wb_req;
			wb_dat_o <= SEAE_RST_WORD;
			if (wb_req && !wb_we_i) begin
				case (wb_adr_i)
					SEAE_OFF_SYNDROME: wb_dat_o <= {24'h00_0000, syndrome};
					SEAE_OFF_CTRL:     wb_dat_o <= {30'h0000_0000, dbp_mode};
					SEAE_OFF_DBP_ADDR: wb_dat_o <= dbp_addr;
					SEAE_OFF_STATUS:   wb_dat_o <= {7'h00, stop_dispatch, 2'h0, state, last_vec};
					default:           wb_dat_o <= SEAE_RST_WORD;
				endcase
			end
		end
	end

	always_ff @(posedge core_clk or posedge reset) begin
		if (reset) begin
			dbp_mode <= SEAE_RST_MODE;
			dbp_addr <= SEAE_RST_WORD;
		end else if (wb_req && wb_we_i) begin
			if (wb_adr_i == SEAE_OFF_CTRL && wb_sel_i[0]) begin
				dbp_mode <= wb_dat_i[SEAE_CTRL_MODE_LSB +: 2];
			end
			if (wb_adr_i == SEAE_OFF_DBP_ADDR) begin
				for (int b = 0; b < 4; b++) begin
					if (wb_sel_i[b]) begin
						dbp_addr[8*b +: 8] <= wb_dat_i[8*b +: 8];
					end
				end
			end
		end
	end

	default clocking cb @(posedge core_clk); endclocking
	default disable iff (reset);

	sequence s_dfault;
		dfault;
	endsequence

	sequence s_redirect_dsi;
		##2 (redirect_valid && redirect_offset == SEAE_VEC_DSI);
	endsequence

	a_dsi_vector: assert property (s_dfault |-> s_redirect_dsi)
		else $error("data fault did not redirect to its vector");

	a_syn_direction: assert property (dfault |=> syndrome[SEAE_SYN_STORE] == $past(dacc.is_store))
		else $error("syndrome direction bit wrong");

	a_syn_before_redir: assert property ((redirect_valid && redirect_offset == SEAE_VEC_DSI) |->
		$past(syndrome) == $past(next_syndrome, 2))
		else $error("redirect came before syndrome update");

	a_isi_vector: assert property ((ifault && !dfault && !afault) |-> ##2
		(redirect_valid && redirect_offset == SEAE_VEC_ISI))
		else $error("fetch fault vector wrong");

	a_align_vector: assert property ((afault && !dfault) |-> ##2
		(redirect_valid && redirect_offset == SEAE_VEC_ALIGN))
		else $error("alignment fault vector wrong");

	a_irq_stop: assert property ((state == seae_st_run && ext_irq && core.external_irq_enable_bit)
		|=> stop_dispatch)
		else $error("dispatch not stopped on interrupt");

	a_irq_drained: assert property ((redirect_valid && redirect_offset == SEAE_VEC_EXT) |->
		$past(core.dispatched_empty && core.external_irq_enable_bit, 2))
		else $error("interrupt taken before drain or while masked");

	a_irq_taken: assert property ((irq_take) |-> ##2
		(redirect_valid && redirect_offset == SEAE_VEC_EXT))
		else $error("interrupt not redirected");

	a_wb_ack_once: assert property (wb_ack_o |=> !wb_ack_o)
		else $error("ack held for two cycles");

	sequence s_redirect_align;
		##2 (redirect_valid && redirect_offset == SEAE_VEC_ALIGN);
	endsequence

	sequence s_redirect_isi;
		##2 (redirect_valid && redirect_offset == SEAE_VEC_ISI);
	endsequence

	a_syn_ds_prog: assert property (dfault |=> syndrome[SEAE_SYN_DS_PROG] == $past(dacc.ds_prog_exc))
		else $error("direct-store program bit wrong");

	a_syn_no_xlat: assert property (dfault |=> syndrome[SEAE_SYN_NO_XLAT] ==
		$past(dacc.miss_primary && dacc.miss_secondary && dacc.miss_block))
		else $error("translation miss bit wrong");

	a_syn_ds_ops: assert property (dfault |=> syndrome[SEAE_SYN_DS_ATOMIC] ==
		$past(dacc.segment_direct_store_flag &&
		dacc.op inside {seae_op_ext_ctl, seae_op_load_reserved, seae_op_store_cond}))
		else $error("direct-store special op bit wrong");

	a_syn_ds_wt: assert property ((dacc.valid && dacc.segment_direct_store_flag && dacc.op == seae_op_ext_ctl &&
		dacc.write_through) |=> syndrome[SEAE_SYN_DS_WT])
		else $error("write-through ext control bit not set");

	a_syn_dbp: assert property ((dacc.valid && dbp_mode == SEAE_MODE_BOTH && dacc.addr[31:2] == dbp_addr[31:2])
		|=> syndrome[SEAE_SYN_DBP])
		else $error("breakpoint bit not set");

	a_syn_seg_miss: assert property (dfault |=> syndrome[SEAE_SYN_SEG_MISS] == $past(dacc.seg_table_miss))
		else $error("segment miss bit wrong");

	a_fetch_dseg: assert property ((fetch.valid && fetch.direct_store_seg && !dacc.valid) |-> s_redirect_isi)
		else $error("direct-store fetch not refused");

	a_dcbz_attr: assert property ((dacc.valid && dacc.op == seae_op_dcbz && !dfault &&
		(dacc.cache_inhibited || dacc.write_through)) |-> s_redirect_align)
		else $error("cache-zero page attribute fault missing");

	a_dcbz_cache: assert property ((dacc.valid && dacc.op == seae_op_dcbz && !dfault &&
		(core.dcache_locked || core.dcache_disabled)) |-> s_redirect_align)
		else $error("cache-zero with cache off fault missing");

	a_le_natural: assert property ((dacc.valid && core.little_endian && dacc.size_log2 == 2'h1 &&
		dacc.addr[0] && !dfault) |-> s_redirect_align)
		else $error("little-endian unaligned fault missing");

	a_le_string: assert property ((dacc.valid && core.little_endian && !dfault &&
		(dacc.op == seae_op_string || dacc.op == seae_op_multiple)) |-> s_redirect_align)
		else $error("little-endian multiple or string fault missing");

	a_irq_masked: assert property ((state == seae_st_run && !core.external_irq_enable_bit) |=> !stop_dispatch)
		else $error("dispatch stopped while interrupt masked");

endmodule // seae_exc

// file: seae_pkg.sv
package seae_pkg;

	localparam int SEAE_DATA_W = 32;
	localparam int SEAE_SYN_W  = 8;
	localparam int SEAE_VEC_W  = 20;

	// register byte offsets
	localparam logic [7:0] SEAE_OFF_SYNDROME = 8'h00;
	localparam logic [7:0] SEAE_OFF_CTRL     = 8'h04;
	localparam logic [7:0] SEAE_OFF_DBP_ADDR = 8'h08;
	localparam logic [7:0] SEAE_OFF_STATUS   = 8'h0C;

	// reset values
	localparam logic [31:0] SEAE_RST_WORD = 32'h0000_0000;
	localparam logic [1:0]  SEAE_RST_MODE = 2'h0;

	// data fault syndrome bit positions
	localparam int SEAE_SYN_DS_PROG   = 0;
	localparam int SEAE_SYN_NO_XLAT   = 1;
	localparam int SEAE_SYN_PROT      = 2;
	localparam int SEAE_SYN_DS_ATOMIC = 3;
	localparam int SEAE_SYN_DS_WT     = 4;
	localparam int SEAE_SYN_STORE     = 5;
	localparam int SEAE_SYN_DBP       = 6;
	localparam int SEAE_SYN_SEG_MISS  = 7;

	// ctrl register: breakpoint compare mode field
	localparam int SEAE_CTRL_MODE_LSB = 0;
	localparam logic [1:0] SEAE_MODE_OFF   = 2'h0;
	localparam logic [1:0] SEAE_MODE_READ  = 2'h1;
	localparam logic [1:0] SEAE_MODE_WRITE = 2'h2;
	localparam logic [1:0] SEAE_MODE_BOTH  = 2'h3;

	// status register field positions
	localparam int SEAE_STAT_VEC_LSB   = 0;
	localparam int SEAE_STAT_STATE_LSB = 20;
	localparam int SEAE_STAT_STOP      = 24;

	// exception vector offsets
	localparam logic [19:0] SEAE_VEC_DSI   = 20'h0_0300;
	localparam logic [19:0] SEAE_VEC_ISI   = 20'h0_0400;
	localparam logic [19:0] SEAE_VEC_EXT   = 20'h0_0500;
	localparam logic [19:0] SEAE_VEC_ALIGN = 20'h0_0600;

	typedef enum logic [2:0] {
		seae_op_other,
		seae_op_fp_ls,
		seae_op_multiple,
		seae_op_load_reserved,
		seae_op_store_cond,
		seae_op_ext_ctl,
		seae_op_string,
		seae_op_dcbz
	} seae_op_t;

	typedef enum logic [1:0] {
		seae_st_run,
		seae_st_drain,
		seae_st_release
	} seae_state_t;

	typedef struct packed {
		logic        valid;
		logic        is_store;
		seae_op_t    op;
		logic [31:0] addr;
		logic [1:0]  size_log2;
		logic        ds_prog_exc;
		logic        miss_primary;
		logic        miss_secondary;
		logic        miss_block;
		logic        prot_denied;
		logic        segment_direct_store_flag;
		logic        write_through;
		logic        cache_inhibited;
		logic        seg_table_miss;
	} seae_dacc_t;

	typedef struct packed {
		logic       valid;
		logic       xlat_fail;
		logic       direct_store_seg;
		logic       supervisor_key_bit;
		logic       user_key_bit;
		logic       problem_state;
		logic [1:0] page_protection_bits;
	} seae_fetch_t;

	typedef struct packed {
		logic little_endian;
		logic dcache_locked;
		logic dcache_disabled;
		logic dispatched_empty;
		logic external_irq_enable_bit;
	} seae_core_t;

endpackage

// file: seae_irq_src.sv
`timescale 1ns/1ps

module seae_irq_src
	import seae_pkg::*;
(
	input  wire logic                  core_clk,
	input  wire logic                  reset,
	input  wire logic                  raise,
	input  wire logic                  redirect_valid,
	input  wire logic [SEAE_VEC_W-1:0] redirect_offset,
	output logic                       ext_irq
);
	always_ff @(posedge core_clk or posedge reset) begin
		if (reset)
			ext_irq <= 1'b0;
		else if (redirect_valid && redirect_offset == SEAE_VEC_EXT)
			ext_irq <= 1'b0;
		else if (raise)
			ext_irq <= 1'b1;
	end
endmodule // seae_irq_src

// file: seae_exc_test.sv
`timescale 1ns/1ps

module seae_exc_test
	import seae_pkg::*;
;
	logic              core_clk, reset, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, raise, ext_irq;
	logic              stop_dispatch, redirect_valid;
	logic [7:0]        wb_adr_i;
	logic [3:0]        wb_sel_i;
	logic [31:0]       wb_dat_i, wb_dat_o, rd;
	logic [19:0]       redirect_offset;
	seae_dacc_t        dacc, d;
	seae_fetch_t       fetch, f;
	seae_core_t        core;
	int                err_total, checked, cycles;

	seae_exc DUT (.core_clk(core_clk), .reset(reset), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
		.wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
		.wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .dacc(dacc), .fetch(fetch), .core(core),
		.ext_irq(ext_irq), .stop_dispatch(stop_dispatch), .redirect_valid(redirect_valid),
		.redirect_offset(redirect_offset));

	seae_irq_src src (.core_clk(core_clk), .reset(reset), .raise(raise), .redirect_valid(redirect_valid),
		.redirect_offset(redirect_offset), .ext_irq(ext_irq));

	initial begin
		core_clk = 1'b0;
		forever #5 core_clk = ~core_clk;
	end

	task automatic tally_and_finish();
		$display("comparisons %0d mismatches %0d", checked, err_total);
		if (err_total == 0 && checked > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask

	always @(posedge core_clk) begin
		cycles++;
		if (cycles == 5000) begin
			err_total++;
			tally_and_finish();
		end
	end

	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		checked++;
		if (g !== e) begin
			err_total++;
			$display("[ERR] %s expected %h seen %h", nm, e, g);
		end
	endtask

	// one classic cycle: hold until ack is sampled, then release for a cycle
	task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] wd);
		int n;
		@(posedge core_clk);
		wb_cyc_i <= 1'b1;
		wb_stb_i <= 1'b1;
		wb_we_i <= we;
		wb_adr_i <= a;
		wb_dat_i <= wd;
		n = 0;
		do begin
			@(posedge core_clk);
			n++;
		end while (wb_ack_o !== 1'b1 && n < 20);
		rd = wb_dat_o;
		chk("ack", 32'h0000_0001, {31'h0, wb_ack_o});
		wb_cyc_i <= 1'b0;
		wb_stb_i <= 1'b0;
	endtask

	// present one report for a cycle and expect one redirect to the offset
	task automatic ev(input seae_dacc_t dv, input seae_fetch_t fv, input logic [19:0] off);
		int n;
		@(posedge core_clk);
		dacc <= dv;
		fetch <= fv;
		@(posedge core_clk);
		dacc <= '0;
		fetch <= '0;
		n = 0;
		while (redirect_valid !== 1'b1 && n < 8) begin
			@(posedge core_clk);
			n++;
		end
		chk("redirect_valid", 32'h0000_0001, {31'h0, redirect_valid});
		chk("redirect_offset", {12'h000, off}, {12'h000, redirect_offset});
	endtask

	task automatic df(input seae_dacc_t dv, input logic [31:0] syn);
		ev(dv, '0, SEAE_VEC_DSI);
		wb(1'b0, SEAE_OFF_SYNDROME, 32'h0000_0000);
		chk("syndrome", syn, rd);
	endtask

	function automatic seae_dacc_t base();
		seae_dacc_t b;
		b = '0;
		b.valid = 1'b1;
		b.addr = 32'h0000_1000;
		b.size_log2 = 2'h2;
		return b;
	endfunction

	initial begin
		reset = 1'b1;
		{wb_cyc_i, wb_stb_i, wb_we_i, raise} = '0;
		wb_adr_i = 8'h00;
		wb_sel_i = 4'hf;
		wb_dat_i = 32'h0000_0000;
		{dacc, fetch, core} = '0;
		{err_total, checked, cycles} = '0;
		repeat (2) @(posedge core_clk);
		reset <= 1'b0;
		for (int i = 0; i < 4; i++) begin
			wb(1'b0, 8'(i * 4), 32'h0000_0000);
			chk("reset value", 32'h0000_0000, rd);
		end
		wb(1'b1, SEAE_OFF_SYNDROME, 32'h0000_00ff);
		wb(1'b0, SEAE_OFF_SYNDROME, 32'h0000_0000);
		chk("syndrome read only", 32'h0000_0000, rd);
		wb(1'b0, 8'h10, 32'h0000_0000);
		chk("unmapped", 32'h0000_0000, rd);
		wb(1'b1, SEAE_OFF_DBP_ADDR, 32'h0000_1000);
		wb(1'b0, SEAE_OFF_DBP_ADDR, 32'h0000_0000);
		chk("breakpoint addr", 32'h0000_1000, rd);
		$display("registers done");
		d = base(); d.ds_prog_exc = 1'b1; df(d, 32'h0000_0001);
		d = base(); {d.miss_primary, d.miss_secondary, d.miss_block} = 3'h7; df(d, 32'h0000_0002);
		d = base(); d.prot_denied = 1'b1; d.is_store = 1'b1; df(d, 32'h0000_0024);
		d = base(); d.segment_direct_store_flag = 1'b1; d.op = seae_op_load_reserved; df(d, 32'h0000_0008);
		d = base(); d.segment_direct_store_flag = 1'b1; d.op = seae_op_ext_ctl; d.write_through = 1'b1;
		df(d, 32'h0000_0018);
		d = base(); d.seg_table_miss = 1'b1; df(d, 32'h0000_0080);
		wb(1'b1, SEAE_OFF_CTRL, {30'h0, SEAE_MODE_READ});
		d = base(); df(d, 32'h0000_0040);
		wb(1'b1, SEAE_OFF_CTRL, {30'h0, SEAE_MODE_WRITE});
		d = base(); d.is_store = 1'b1; df(d, 32'h0000_0060);
		wb(1'b1, SEAE_OFF_CTRL, {30'h0, SEAE_MODE_BOTH});
		wb(1'b0, SEAE_OFF_CTRL, 32'h0000_0000);
		chk("ctrl", 32'h0000_0003, rd);
		d = base(); d.is_store = 1'b1; df(d, 32'h0000_0060);
		wb(1'b1, SEAE_OFF_CTRL, 32'h0000_0000);
		$display("data faults done");
		d = base(); d.op = seae_op_fp_ls; d.addr = 32'h0000_1002; ev(d, '0, SEAE_VEC_ALIGN);
		d = base(); d.op = seae_op_store_cond; d.addr = 32'h0000_1001; ev(d, '0, SEAE_VEC_ALIGN);
		d = base(); d.op = seae_op_dcbz; d.cache_inhibited = 1'b1; ev(d, '0, SEAE_VEC_ALIGN);
		d = base(); d.op = seae_op_dcbz; d.write_through = 1'b1; ev(d, '0, SEAE_VEC_ALIGN);
		core.dcache_disabled <= 1'b1;
		d = base(); d.op = seae_op_dcbz; ev(d, '0, SEAE_VEC_ALIGN);
		core <= seae_core_t'{dcache_locked: 1'b1, default: 1'b0};
		ev(d, '0, SEAE_VEC_ALIGN);
		core <= seae_core_t'{little_endian: 1'b1, default: 1'b0};
		d = base(); d.addr = 32'h0000_1001; d.size_log2 = 2'h1; ev(d, '0, SEAE_VEC_ALIGN);
		d = base(); d.op = seae_op_string; ev(d, '0, SEAE_VEC_ALIGN);
		d = base(); d.op = seae_op_multiple; ev(d, '0, SEAE_VEC_ALIGN);
		core <= '0;
		f = '0; f.valid = 1'b1; f.xlat_fail = 1'b1; ev('0, f, SEAE_VEC_ISI);
		f = '0; f.valid = 1'b1; f.direct_store_seg = 1'b1; ev('0, f, SEAE_VEC_ISI);
		f = '0; f.valid = 1'b1; f.supervisor_key_bit = 1'b1; ev('0, f, SEAE_VEC_ISI);
		f = '0; f.valid = 1'b1; f.problem_state = 1'b1; f.user_key_bit = 1'b1; ev('0, f, SEAE_VEC_ISI);
		$display("alignment and fetch done");
		@(posedge core_clk);
		raise <= 1'b1;
		@(posedge core_clk);
		raise <= 1'b0;
		repeat (6) @(posedge core_clk);
		chk("masked stop", 32'h0000_0000, {31'h0, stop_dispatch});
		core.external_irq_enable_bit <= 1'b1;
		repeat (6) @(posedge core_clk);
		chk("draining stop", 32'h0000_0001, {31'h0, stop_dispatch});
		d = base(); d.prot_denied = 1'b1;
		@(posedge core_clk);
		dacc <= d;
		core.dispatched_empty <= 1'b1;
		ev('0, '0, SEAE_VEC_DSI);
		chk("held for fault", 32'h0000_0001, {31'h0, stop_dispatch});
		ev('0, '0, SEAE_VEC_EXT);
		wb(1'b0, SEAE_OFF_SYNDROME, 32'h0000_0000);
		chk("syndrome", 32'h0000_0004, rd);
		repeat (3) @(posedge core_clk);
		chk("pin released", 32'h0000_0000, {31'h0, ext_irq});
		wb(1'b0, SEAE_OFF_STATUS, 32'h0000_0000);
		chk("status", 32'h0000_0500, rd);
		$display("interrupt done");
		tally_and_finish();
	end
endmodule // seae_exc_test
